// File: hw/bla_exec.sv
// executes bit clear/set, bit-test skips, add and and forms, watchdog clear
// assumes the file register port answers combinationally on o_file_addr
// and that port pin levels arrive asynchronously
//
// Contract
// - bit clear forces chosen bit of addressed file register to zero, flags kept
// - bit set forces chosen bit of addressed file register to one, flags kept
// - add of accumulator and file register updates carry, nibble and zero flags
// - destination bit 0 writes accumulator, 1 writes file register back
// - and with literal writes accumulator, only zero flag changes
// - and with file register follows destination bit, only zero flag changes
// - skip-if-clear discards next instruction when tested bit is zero
// - skip-if-set discards next instruction when tested bit is one
// - watchdog clear resets watchdog count and its prescaler; the code pulses o_watchdog_clear only, never o_prescaler_clear
// - watchdog clear sets watchdog expiry and power down flags to one
// - bit ops decode as 01, two-bit op, three-bit index, seven-bit address
// - read-modify-write of a port register reads the pin levels
// - writing timer zero clears prescaler when it is assigned there
module bla_exec (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // instruction issue
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   output logic o_instr_ready,
   // file register port
   output logic [6:0] o_file_addr,
   input wire logic [7:0] i_file_rdata,
   output logic o_file_we,
   output logic [7:0] o_file_wdata,
   // port pin levels
   input wire logic [15:0] i_port_pins,
   // core side effects
   output logic [7:0] o_acc,
   output logic [5:0] o_status,
   output logic o_skip,
   output logic o_watchdog_clear,
   output logic o_prescaler_clear,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);

   typedef struct packed {
      logic [15:0] pins_meta;
      logic [15:0] pins_sync;
      bla_pkg::bla_state_type state;
      logic [13:0] opcode;
      logic skip_pend;
      logic [7:0] acc;
      logic carry;
      logic nibble;
      logic zero;
      logic wdt_expiry;
      logic power_down;
      logic instr_ready;
      logic [6:0] file_addr;
      logic file_we;
      logic [7:0] file_wdata;
      logic skip;
      logic wdt_clear;
      logic pre_clear;
      logic [1:0] ctrl;
      logic [31:0] count;
      logic avs_wait;
      logic [31:0] avs_rdata;
   } bla_core_type;

   bla_core_type q;
   bla_core_type d;

   // decode of the held opcode
   logic [1:0] op_class;
   logic [1:0] bit_op;
   logic [2:0] bit_idx;
   logic [5:0] op_sel;
   logic dest_file;
   logic [7:0] literal;
   logic is_bit_op;
   logic is_add_file;
   logic is_and_file;
   logic is_and_lit;
   logic is_wdt_clear;

   // operand and results
   logic [7:0] operand;
   logic [7:0] bit_mask;
   logic [8:0] add_sum;
   logic [4:0] nibble_sum;
   logic [7:0] and_file;
   logic [7:0] and_lit;
   logic tested_bit;
   logic [7:0] status_word;

   assign op_class = q.opcode[bla_pkg::OP_CLASS_HI:bla_pkg::OP_CLASS_LO];
   assign bit_op = q.opcode[bla_pkg::OP_BITOP_HI:bla_pkg::OP_BITOP_LO];
   assign bit_idx = q.opcode[bla_pkg::OP_BIDX_HI:bla_pkg::OP_BIDX_LO];
   assign op_sel = q.opcode[bla_pkg::OP_SEL_HI:bla_pkg::OP_SEL_LO];
   assign dest_file = q.opcode[bla_pkg::OP_DEST_BIT];
   assign literal = q.opcode[7:0];

   assign is_bit_op = (op_class == bla_pkg::CLASS_BIT);
   assign is_add_file = (op_sel == bla_pkg::SEL_ADD_ACC_FILE);
   assign is_and_file = (op_sel == bla_pkg::SEL_AND_ACC_FILE);
   assign is_and_lit = (op_sel == bla_pkg::SEL_AND_LITERAL);
   assign is_wdt_clear = (q.opcode == bla_pkg::OPC_WATCHDOG_CLEAR);

   // port registers read back the synchronised pins
   always_comb begin
      if (q.file_addr == bla_pkg::ADDR_PORT_A) begin
         operand = q.pins_sync[7:0];
      end else if (q.file_addr == bla_pkg::ADDR_PORT_B) begin
         operand = q.pins_sync[15:8];
      end else begin
         operand = i_file_rdata;
      end
   end

   // one-hot mask of the selected bit
   genvar gi;
   generate
      for (gi = 0; gi < bla_pkg::DATA_W; gi++) begin : g_mask
         assign bit_mask[gi] = (bit_idx == 3'(gi));
      end
   endgenerate

   assign add_sum = {1'b0, q.acc} + {1'b0, operand};
   assign nibble_sum = {1'b0, q.acc[3:0]} + {1'b0, operand[3:0]};
   assign and_file = q.acc & operand;
   assign and_lit = q.acc & literal;
   assign tested_bit = |(operand & bit_mask);

   always_comb begin
      status_word = 8'h00;
      status_word[bla_pkg::ST_CARRY] = q.carry;
      status_word[bla_pkg::ST_NIBBLE] = q.nibble;
      status_word[bla_pkg::ST_ZERO] = q.zero;
      status_word[bla_pkg::ST_POWER_DOWN] = q.power_down;
      status_word[bla_pkg::ST_WDT_EXPIRY] = q.wdt_expiry;
      status_word[bla_pkg::ST_SKIP_PEND] = q.skip_pend;
   end

   always_comb begin
      d = q;
      d.pins_meta = i_port_pins;
      d.pins_sync = q.pins_meta;
      d.file_we = 1'b0;
      d.skip = 1'b0;
      d.wdt_clear = 1'b0;
      d.pre_clear = 1'b0;

      case (q.state)
         bla_pkg::ST_FETCH: begin
            if (q.instr_ready && i_instr_valid) begin
               d.instr_ready = 1'b0;
               d.count = q.count + 32'h0000_0001;
               if (q.skip_pend) begin
                  // discarded word runs as a no-operation cycle
                  d.skip_pend = 1'b0;
                  d.opcode = 14'h0000;
                  d.skip = 1'b1;
               end else begin
                  d.opcode = i_instr;
                  d.file_addr = i_instr[6:0];
               end
               d.state = bla_pkg::ST_EXEC;
            end else begin
               d.instr_ready = q.ctrl[bla_pkg::CTRL_EXEC_EN];
            end
         end
         bla_pkg::ST_EXEC: begin
            d.state = bla_pkg::ST_FETCH;
            d.instr_ready = q.ctrl[bla_pkg::CTRL_EXEC_EN];
            if (is_bit_op) begin
               case (bit_op)
                  bla_pkg::BITOP_CLEAR: begin
                     d.file_we = 1'b1;
                     d.file_wdata = operand & ~bit_mask;
                  end
                  bla_pkg::BITOP_SET: begin
                     d.file_we = 1'b1;
                     d.file_wdata = operand | bit_mask;
                  end
                  bla_pkg::BITOP_SKIP_CLR: begin
                     d.skip_pend = ~tested_bit;
                  end
                  bla_pkg::BITOP_SKIP_SET: begin
                     d.skip_pend = tested_bit;
                  end
                  default: begin
                     d.skip_pend = 1'b0;
                  end
               endcase
            end else if (is_add_file) begin
               d.carry = add_sum[8];
               d.nibble = nibble_sum[4];
               d.zero = (add_sum[7:0] == 8'h00);
               if (dest_file == bla_pkg::DEST_ACC) begin
                  d.acc = add_sum[7:0];
               end else begin
                  d.file_we = 1'b1;
                  d.file_wdata = add_sum[7:0];
               end
            end else if (is_and_file) begin
               d.zero = (and_file == 8'h00);
               if (dest_file == bla_pkg::DEST_ACC) begin
                  d.acc = and_file;
               end else begin
                  d.file_we = 1'b1;
                  d.file_wdata = and_file;
               end
            end else if (is_and_lit) begin
               d.acc = and_lit;
               d.zero = (and_lit == 8'h00);
            end else if (is_wdt_clear) begin
               d.wdt_clear = 1'b1;
               d.wdt_expiry = 1'b1;
               d.power_down = 1'b1;
            end
            // timer zero written while the shared prescaler serves it
            if (d.file_we && (q.file_addr == bla_pkg::ADDR_TIMER0)
                  && q.ctrl[bla_pkg::CTRL_PRESCALE_TMR0]) begin
               d.pre_clear = 1'b1;
            end
         end
         default: begin
            d.state = bla_pkg::ST_FETCH;
         end
      endcase

      // avalon slave: one wait cycle, then the transfer completes
      if ((i_avs_read || i_avs_write) && q.avs_wait) begin
         d.avs_wait = 1'b0;
         case (i_avs_address)
            bla_pkg::REG_CTRL: d.avs_rdata = {30'h0000_0000, q.ctrl};
            bla_pkg::REG_STATUS: d.avs_rdata = {24'h00_0000, status_word};
            bla_pkg::REG_ACC: d.avs_rdata = {24'h00_0000, q.acc};
            bla_pkg::REG_COUNT: d.avs_rdata = q.count;
            default: d.avs_rdata = 32'h0000_0000;
         endcase
      end else begin
         d.avs_wait = 1'b1;
      end
      if (i_avs_write && !q.avs_wait && i_avs_byteenable[0]) begin
         if (i_avs_address == bla_pkg::REG_CTRL) begin
            d.ctrl = i_avs_writedata[1:0];
         end else if (i_avs_address == bla_pkg::REG_COUNT) begin
            d.count = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         q.pins_meta <= 16'h0000;
         q.pins_sync <= 16'h0000;
         q.state <= bla_pkg::ST_FETCH;
         q.opcode <= 14'h0000;
         q.skip_pend <= 1'b0;
         q.acc <= bla_pkg::ACC_RESET;
         q.carry <= 1'b0;
         q.nibble <= 1'b0;
         q.zero <= 1'b0;
         q.wdt_expiry <= bla_pkg::FLAG_TO_RESET;
         q.power_down <= bla_pkg::FLAG_PD_RESET;
         q.instr_ready <= 1'b0;
         q.file_addr <= 7'h00;
         q.file_we <= 1'b0;
         q.file_wdata <= 8'h00;
         q.skip <= 1'b0;
         q.wdt_clear <= 1'b0;
         q.pre_clear <= 1'b0;
         q.ctrl <= bla_pkg::CTRL_RESET;
         q.count <= 32'h0000_0000;
         q.avs_wait <= 1'b1;
         q.avs_rdata <= 32'h0000_0000;
      end else begin
         q <= d;
      end
   end

   assign o_instr_ready = q.instr_ready;
   assign o_file_addr = q.file_addr;
   assign o_file_we = q.file_we;
   assign o_file_wdata = q.file_wdata;
   assign o_acc = q.acc;
   assign o_status = status_word[5:0];
   assign o_skip = q.skip;
   assign o_watchdog_clear = q.wdt_clear;
   assign o_prescaler_clear = q.pre_clear;
   assign o_avs_readdata = q.avs_rdata;
   assign o_avs_waitrequest = q.avs_wait;

endmodule

// File: hw/bla_pkg.sv
// constants and types for the bit, logic and add instruction executor
// assumes a 14-bit opcode word and a 128-entry file register space
package bla_pkg;

   // data path widths
   localparam int OPCODE_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int BIDX_W = 3;
   localparam int PORT_COUNT = 2;
   localparam int PINS_W = PORT_COUNT * DATA_W;

   // opcode field positions
   localparam int OP_CLASS_HI = 13;
   localparam int OP_CLASS_LO = 12;
   localparam int OP_BITOP_HI = 11;
   localparam int OP_BITOP_LO = 10;
   localparam int OP_BIDX_HI = 9;
   localparam int OP_BIDX_LO = 7;
   localparam int OP_DEST_BIT = 7;
   localparam int OP_SEL_HI = 13;
   localparam int OP_SEL_LO = 8;

   // opcode encodings
   localparam logic [1:0] CLASS_BIT = 2'h1;
   localparam logic [1:0] BITOP_CLEAR = 2'h0;
   localparam logic [1:0] BITOP_SET = 2'h1;
   localparam logic [1:0] BITOP_SKIP_CLR = 2'h2;
   localparam logic [1:0] BITOP_SKIP_SET = 2'h3;
   localparam logic [5:0] SEL_ADD_ACC_FILE = 6'h07;
   localparam logic [5:0] SEL_AND_ACC_FILE = 6'h05;
   localparam logic [5:0] SEL_AND_LITERAL = 6'h39;
   localparam logic [13:0] OPC_WATCHDOG_CLEAR = 14'h0064;
   localparam logic DEST_ACC = 1'b0;

   // special file register addresses
   localparam logic [6:0] ADDR_TIMER0 = 7'h01;
   localparam logic [6:0] ADDR_PORT_A = 7'h05;
   localparam logic [6:0] ADDR_PORT_B = 7'h06;

   // register map, byte addresses
   localparam int AVS_ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_ACC = 4'h8;
   localparam logic [3:0] REG_COUNT = 4'hc;

   // control register fields and reset value
   localparam int CTRL_W = 2;
   localparam int CTRL_PRESCALE_TMR0 = 0;
   localparam int CTRL_EXEC_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;

   // status register fields
   localparam int ST_CARRY = 0;
   localparam int ST_NIBBLE = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_POWER_DOWN = 3;
   localparam int ST_WDT_EXPIRY = 4;
   localparam int ST_SKIP_PEND = 5;
   localparam int ST_W = 6;

   // reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic FLAG_TO_RESET = 1'b1;
   localparam logic FLAG_PD_RESET = 1'b1;

   typedef enum logic [0:0] {ST_FETCH, ST_EXEC} bla_state_type;

endpackage

// File: bench/bla_exec_monitor.sv
// assertions on the instruction side of bla_exec
// assumes it is bound to bla_exec on one clock with synchronous reset
module bla_exec_monitor (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // watched ports
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   input wire logic o_instr_ready,
   input wire logic [7:0] i_file_rdata,
   input wire logic o_file_we,
   input wire logic [7:0] o_file_wdata,
   input wire logic [7:0] o_acc,
   input wire logic [5:0] o_status,
   input wire logic o_watchdog_clear
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   logic [13:0] op_q;
   logic [7:0] acc_q;
   logic [7:0] fd_q;
   logic ph_q;
   logic take;
   assign take = o_instr_ready && i_instr_valid && !o_status[5];
   always_ff @(posedge i_clock) begin
      ph_q <= !i_reset && o_instr_ready && i_instr_valid;
      if (o_instr_ready && i_instr_valid) begin
         op_q <= i_instr;
         acc_q <= o_acc;
      end
      if (ph_q) begin
         fd_q <= i_file_rdata;
      end
   end
   sequence s_bitop(logic [1:0] op);
      take && i_instr[13:10] == {2'h1, op};
   endsequence
   sequence s_add_acc;
      take && i_instr[13:8] == bla_pkg::SEL_ADD_ACC_FILE && !i_instr[7];
   endsequence
   a_clear_bit_low: assert property (s_bitop(2'h0) |-> ##2 o_file_we &&
      !o_file_wdata[op_q[9:7]] && $stable(o_status[2:0])) else $error("bit clear wrong");
   a_set_bit_high: assert property (s_bitop(2'h1) |-> ##2 o_file_we &&
      o_file_wdata[op_q[9:7]] && $stable(o_status[2:0])) else $error("bit set wrong");
   a_add_sum_carry: assert property (s_add_acc |-> ##2
      {o_status[0], o_acc} == {1'b0, acc_q} + {1'b0, fd_q}) else $error("add sum wrong");
   a_add_zero_nibble: assert property (s_add_acc |-> ##2 o_status[2] == (o_acc == 8'h00) &&
      o_status[1] == ({1'b0, acc_q[3:0]} + {1'b0, fd_q[3:0]} > 5'h0f)) else $error("add flags");
   a_dest_to_file: assert property (take && i_instr[7] && (i_instr[13:8] == 6'h07 ||
      i_instr[13:8] == 6'h05) |-> ##2 o_file_we && $stable(o_acc)) else $error("dest wrong");
   a_literal_and: assert property (take && i_instr[13:8] == 6'h39 |-> ##2
      o_acc == (acc_q & op_q[7:0]) && $stable(o_status[1:0])) else $error("literal and wrong");
   a_wdt_flags_set: assert property (take && i_instr == 14'h0064 |-> ##2
      o_watchdog_clear && o_status[4:3] == 2'h3) else $error("watchdog flags wrong");
   a_wdt_one_pulse: assert property ($rose(o_watchdog_clear) |=> !o_watchdog_clear)
      else $error("watchdog clear too long");
endmodule
bind bla_exec bla_exec_monitor u_mon (.i_clock(i_clock), .i_reset(i_reset),
   .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_instr_ready(o_instr_ready),
   .i_file_rdata(i_file_rdata), .o_file_we(o_file_we), .o_file_wdata(o_file_wdata),
   .o_acc(o_acc), .o_status(o_status), .o_watchdog_clear(o_watchdog_clear));

// File: bench/tb_bit_logic_add_instr_exec.sv
// self-checking bench for bla_exec: row table, then skips, watchdog, ports, bus
// assumes a combinational file register model kept in this bench
module tb_bit_logic_add_instr_exec;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [13:0] op; logic [7:0] acc; logic [2:0] fl; logic we; logic [7:0] wd;}
      bla_row_type;
   logic i_clock = 0, i_reset = 1, i_instr_valid = 0, i_avs_read = 0, i_avs_write = 0;
   logic [13:0] i_instr = 14'h0000;
   logic [15:0] i_port_pins = 16'h55a0;
   logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
   logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata, q;
   logic o_instr_ready, o_file_we, o_skip, o_watchdog_clear, o_prescaler_clear, o_avs_waitrequest;
   logic [6:0] o_file_addr;
   logic [7:0] i_file_rdata, o_file_wdata, o_acc, mem [128];
   logic [5:0] o_status;
   int err_total = 0, checked = 0, skips = 0, wdts = 0, pres = 0;
   bla_row_type rows [13] = '{'{14'h0720, 8'h3c, 3'h0, 0, 8'h00}, '{14'h0721, 8'h00, 3'h7, 0, 8'h00},
      '{14'h0722, 8'h0f, 3'h0, 0, 8'h00}, '{14'h0723, 8'h07, 3'h3, 0, 8'h00},
      '{14'h3904, 8'h04, 3'h3, 0, 8'h00}, '{14'h3908, 8'h00, 3'h7, 0, 8'h00},
      '{14'h0720, 8'h3c, 3'h0, 0, 8'h00}, '{14'h1420, 8'h3c, 3'h0, 1, 8'h3d},
      '{14'h1120, 8'h3c, 3'h0, 1, 8'h39}, '{14'h07a2, 8'h3c, 3'h2, 1, 8'h4b},
      '{14'h05a1, 8'h3c, 3'h2, 1, 8'h04}, '{14'h0523, 8'h38, 3'h2, 0, 8'h00},
      '{14'h17a1, 8'h38, 3'h2, 1, 8'h84}};
   assign i_file_rdata = mem[o_file_addr];
   bla_exec DUT (.i_clock(i_clock), .i_reset(i_reset), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_file_addr(o_file_addr),
      .i_file_rdata(i_file_rdata), .o_file_we(o_file_we), .o_file_wdata(o_file_wdata),
      .i_port_pins(i_port_pins), .o_acc(o_acc), .o_status(o_status), .o_skip(o_skip),
      .o_watchdog_clear(o_watchdog_clear), .o_prescaler_clear(o_prescaler_clear),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
   initial begin
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      if (o_file_we) mem[o_file_addr] <= o_file_wdata;
   end
   // pulses counted away from the edge
   always @(negedge i_clock) begin
      skips += o_skip;
      wdts += o_watchdog_clear;
      pres += o_prescaler_clear;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // hold the opcode until taken, return when results stand
   task automatic exec(input logic [13:0] op);
      @(posedge i_clock);
      i_instr <= op;
      i_instr_valid <= 1'b1;
      do begin
         @(posedge i_clock);
      end while (o_instr_ready !== 1'b1);
      i_instr_valid <= 1'b0;
      @(posedge i_clock);
      #1;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_writedata <= d;
      #1;
      while (o_avs_waitrequest !== 1'b0) begin
         @(posedge i_clock);
         #1;
      end
      @(posedge i_clock);
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task automatic complete_run;
      $display("counts: checked %0d, wrong %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      complete_run();
   end
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      mem[32] = 8'h3c;
      mem[33] = 8'hc4;
      mem[34] = 8'h0f;
      mem[35] = 8'hf8;
      repeat (12) @(posedge i_clock);
      i_reset <= 1'b0;
      @(posedge i_clock);
      #1;
      cmp(o_status, 6'h18);
      cmp(o_acc, 8'h00);
      $display("reset test done");
      foreach (rows[i]) begin
         exec(rows[i].op);
         cmp(o_acc, rows[i].acc);
         cmp(o_status[2:0], rows[i].fl);
         cmp(o_file_we, rows[i].we);
         if (rows[i].we) cmp(o_file_wdata, rows[i].wd);
      end
      $display("row tests done");
      exec(14'h18a0);
      exec(14'h3900);
      cmp(o_acc, 8'h38);
      exec(14'h1c20);
      exec(14'h3900);
      cmp(o_acc, 8'h38);
      exec(14'h1820);
      exec(14'h390f);
      cmp(o_acc, 8'h08);
      exec(14'h1ca0);
      exec(14'h390c);
      cmp(o_acc, 8'h08);
      exec(14'h0064);
      cmp(o_status[4:3], 2'h3);
      exec(14'h1405);
      cmp(o_file_wdata, 8'ha1);
      exec(14'h1401);
      bus(1'b1, 4'h0, 32'h0000_0003);
      exec(14'h1401);
      repeat (2) @(posedge i_clock);
      cmp(skips, 2);
      cmp(wdts, 1);
      cmp(pres, 1);
      $display("skip, watchdog and port tests done");
      bus(1'b0, 4'h8, 32'h0000_0000);
      cmp(q, 32'h0000_0008);
      bus(1'b0, 4'h2, 32'h0000_0000);
      cmp(q, 32'h0000_0000);
      bus(1'b0, 4'h0, 32'h0000_0000);
      cmp(q, 32'h0000_0003);
      bus(1'b0, 4'h4, 32'h0000_0000);
      cmp(q, 32'h0000_001a);
      $display("bus tests done");
      complete_run();
   end
endmodule
